// ==== hw/accel_tap_detect_rate_ctrl.v ====
// Output data rate control, tap detection, tap flags and tap interrupt pin
//
// How it works
// - Rate codes 0-7 give 32 down to 0.25 Hz; 8-10 give 64-256 Hz.
// - Per-axis swap bits 4,5,6 exchange positive and negative tap direction.
// - Latch bit clear: every enabled tap sets its flag; flags accumulate.
// - Latch bit set: only the first tap recorded until status read at 0x03.
// - Tap control bits 5:0 enable each axis and direction separately.
// - Tap control bit 7 is a global enable over all per-direction enables.
// - Tap control bit 6 steers writes at 0x0a-0x0c to duration or threshold.
// - Duration view: quiet count in bits 7:4, duration count in bits 3:0.
// - Threshold view: full 8-bit threshold, stored apart from duration/quiet.
// - Events above threshold longer than the duration count give no tap.
// - After a tap the axis ignores quiet-count samples, then re-arms.
// - Tap considered only when magnitude reaches the 8-bit unsigned threshold.
// - Flags set and clear regardless of interrupt enables; enables gate pin.
// - Operating state: 00 standby (reset), 01 wake, others reserved.
`timescale 1ns/1ps
`include "accel_tap_map.vh"
module accel_tap_detect_rate_ctrl #(
    parameter [31:0] CLK_HZ = `CLK_HZ
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // Register write port
    input  wire        wr_en,
    input  wire [7:0]  wr_addr,
    input  wire [7:0]  wr_data,
    // Register read port
    input  wire        rd_en,
    input  wire [7:0]  rd_addr,
    output reg  [7:0]  rd_data,
    output reg         rd_valid,
    // Samples from the converter, same clock
    input  wire [15:0] x_sample,
    input  wire [15:0] y_sample,
    input  wire [15:0] z_sample,
    // Status and interrupt
    output reg  [5:0]  tap_flags,
    output reg         accel_irq_pin
);

// ----------------------------------------------------------------------------
// Configuration registers
// ----------------------------------------------------------------------------
reg  [7:0]  sample_rate_tap_feature;
reg  [7:0]  tap_control;
reg  [7:0]  irq_enable_reg;
reg  [1:0]  operating_state;
reg  [7:0]  duration_bank [0:2];
reg  [7:0]  threshold_bank [0:2];

// ----------------------------------------------------------------------------
// Decoded controls
// ----------------------------------------------------------------------------
wire [3:0]  rate_code;
wire        latch_mode;
wire        param_bank_select;
wire        global_enable;
wire [5:0]  detect_enable;
wire [2:0]  direction_swap;
wire        wake;
wire        sample_strobe;
wire [15:0] samples [0:2];
wire [5:0]  taps;

assign rate_code         = sample_rate_tap_feature[`RATE_MSB:`RATE_LSB];
assign latch_mode        = sample_rate_tap_feature[`LATCH_MODE_BIT];
assign param_bank_select = tap_control[`PARAM_BANK_SELECT_BIT];
assign global_enable     = tap_control[`GLOBAL_TAP_ENABLE_BIT];
assign direction_swap    = {sample_rate_tap_feature[`Z_SWAP_BIT],
                            sample_rate_tap_feature[`Y_SWAP_BIT],
                            sample_rate_tap_feature[`X_SWAP_BIT]};

// Reserved state codes keep the block idle, as standby does
assign wake = (operating_state == `STATE_WAKE);

// Per-direction enables are ignored while the global enable is low
assign detect_enable = tap_control[`DETECT_ENABLE_MSB:0] & {6{global_enable}};

assign samples[0] = x_sample;
assign samples[1] = y_sample;
assign samples[2] = z_sample;

// ----------------------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------------------
wire        param_write;
wire [1:0]  param_index;

assign param_write = wr_en &&
                     (wr_addr >= `ADDR_TAP_X_PARAMS) &&
                     (wr_addr <= `ADDR_TAP_Z_PARAMS);
assign param_index = wr_addr[1:0] - 2'h2;

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        sample_rate_tap_feature <= `RESET_BYTE;
        tap_control             <= `RESET_BYTE;
        irq_enable_reg          <= `RESET_BYTE;
        operating_state         <= `RESET_STATE;
    end else if (wr_en) begin
        case (wr_addr)
            `ADDR_RATE_TAP_FEATURE: sample_rate_tap_feature <= wr_data;
            `ADDR_TAP_CONTROL:      tap_control             <= wr_data;
            `ADDR_IRQ_ENABLE:       irq_enable_reg          <= wr_data;
            `ADDR_OPERATING_STATE:  operating_state         <= wr_data[1:0];
            default: begin
                // Other offsets are held elsewhere or unmapped; writes drop
            end
        endcase
    end
end

// ----------------------------------------------------------------------------
// Per-axis parameter storage and detectors
// ----------------------------------------------------------------------------
genvar axis;
generate
    for (axis = 0; axis < 3; axis = axis + 1) begin : g_axis
        // Two separate stores share one offset; the bank bit picks the target
        always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                duration_bank[axis]  <= `RESET_BYTE;
                threshold_bank[axis] <= `RESET_BYTE;
            end else if (param_write && (param_index == axis)) begin
                if (param_bank_select) begin
                    threshold_bank[axis] <= wr_data;
                end else begin
                    duration_bank[axis] <= wr_data;
                end
            end
        end

        axis_tap_detector u_detector (
            .clk            (clk),
            .rst_b          (rst_b),
            .sample_strobe  (sample_strobe),
            .sample         (samples[axis]),
            .threshold      (threshold_bank[axis]),
            .max_samples    (duration_bank[axis][`DURATION_MSB:`DURATION_LSB]),
            .quiet_samples  (duration_bank[axis][`QUIET_MSB:`QUIET_LSB]),
            .direction_swap (direction_swap[axis]),
            .pos_enable     (detect_enable[2*axis]),
            .neg_enable     (detect_enable[2*axis+1]),
            .tap_pos        (taps[2*axis]),
            .tap_neg        (taps[2*axis+1])
        );
    end
endgenerate

// ----------------------------------------------------------------------------
// Sample rate
// ----------------------------------------------------------------------------
sample_rate_gen #(
    .CLK_HZ (CLK_HZ)
) u_rate (
    .clk           (clk),
    .rst_b         (rst_b),
    .run           (wake),
    .rate_code     (rate_code),
    .sample_strobe (sample_strobe)
);

// ----------------------------------------------------------------------------
// Tap flags
// ----------------------------------------------------------------------------
reg  [5:0]  next_tap_flags;
reg  [5:0]  accepted;
reg         flags_cleared;
reg         accept_new;

always @* begin
    flags_cleared = rd_en && (rd_addr == `ADDR_EVENT_FLAGS);
    next_tap_flags = flags_cleared ? 6'h00 : tap_flags;
    // A read in the same cycle frees the latch, so an arriving tap is kept
    accept_new = !latch_mode || flags_cleared || (tap_flags == 6'h00);
    if (latch_mode) begin
        // Simultaneous taps: lowest flag position is taken as the first
        accepted = taps & (6'h00 - taps);
    end else begin
        accepted = taps;
    end
    if (!accept_new) begin
        accepted = 6'h00;
    end
    next_tap_flags = next_tap_flags | accepted;
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        tap_flags <= 6'h00;
    end else begin
        tap_flags <= next_tap_flags;
    end
end

// ----------------------------------------------------------------------------
// Interrupt pin
// ----------------------------------------------------------------------------
// Detect enables already gate the flags, so an interrupt enable alone
// cannot raise the pin for a direction that is not detected.
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        accel_irq_pin <= 1'b0;
    end else begin
        accel_irq_pin <= |(next_tap_flags & irq_enable_reg[5:0]);
    end
end

// ----------------------------------------------------------------------------
// Register reads
// ----------------------------------------------------------------------------
// Configuration registers are write-only; only the flags read back.
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        rd_data  <= 8'h00;
        rd_valid <= 1'b0;
    end else begin
        rd_valid <= rd_en;
        if (rd_en && (rd_addr == `ADDR_EVENT_FLAGS)) begin
            rd_data <= {2'b00, tap_flags};
        end else begin
            rd_data <= 8'h00;
        end
    end
end

endmodule // accel_tap_detect_rate_ctrl

// ==== hw/accel_tap_map.vh ====
// Register offsets, field positions, reset values and timing for the tap and rate block
`ifndef ACCEL_TAP_MAP_VH
`define ACCEL_TAP_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_EVENT_FLAGS       8'h03
`define ADDR_IRQ_ENABLE        8'h06
`define ADDR_OPERATING_STATE   8'h07
`define ADDR_RATE_TAP_FEATURE  8'h08
`define ADDR_TAP_CONTROL       8'h09
`define ADDR_TAP_X_PARAMS      8'h0a
`define ADDR_TAP_Y_PARAMS      8'h0b
`define ADDR_TAP_Z_PARAMS      8'h0c

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RESET_BYTE             8'h00
`define RESET_NIBBLE           4'h0
`define RESET_STATE            2'h0

// ----------------------------------------------------------------------------
// Fields of sample_rate_tap_feature
// ----------------------------------------------------------------------------
`define RATE_LSB               0
`define RATE_MSB               3
`define X_SWAP_BIT             4
`define Y_SWAP_BIT             5
`define Z_SWAP_BIT             6
`define LATCH_MODE_BIT         7

// ----------------------------------------------------------------------------
// Fields of tap_control and the parameter registers
// ----------------------------------------------------------------------------
`define DETECT_ENABLE_MSB      5
`define PARAM_BANK_SELECT_BIT  6
`define GLOBAL_TAP_ENABLE_BIT  7
`define DURATION_LSB           0
`define DURATION_MSB           3
`define QUIET_LSB              4
`define QUIET_MSB              7

// ----------------------------------------------------------------------------
// Operating states
// ----------------------------------------------------------------------------
`define STATE_STANDBY          2'h0
`define STATE_WAKE             2'h1

// ----------------------------------------------------------------------------
// Rate codes and timing
// ----------------------------------------------------------------------------
`define RATE_32HZ              4'h0
`define RATE_16HZ              4'h1
`define RATE_8HZ               4'h2
`define RATE_4HZ               4'h3
`define RATE_2HZ               4'h4
`define RATE_1HZ               4'h5
`define RATE_HALF_HZ           4'h6
`define RATE_QUARTER_HZ        4'h7
`define RATE_64HZ              4'h8
`define RATE_128HZ             4'h9
`define RATE_256HZ             4'ha
`define CLK_HZ                 50000000

`endif

// ==== hw/axis_tap_detector.v ====
// Tap detector for one axis: threshold, duration limit, quiet time and swap
`timescale 1ns/1ps
module axis_tap_detector (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_b,
    input  wire        sample_strobe,
    // Sample, two's complement
    input  wire [15:0] sample,
    // Settings
    input  wire [7:0]  threshold,
    input  wire [3:0]  max_samples,
    input  wire [3:0]  quiet_samples,
    input  wire        direction_swap,
    input  wire        pos_enable,
    input  wire        neg_enable,
    // Detected taps
    output reg         tap_pos,
    output reg         tap_neg
);

localparam [1:0] IDLE   = 2'h0;
localparam [1:0] ABOVE  = 2'h1;
localparam [1:0] REJECT = 2'h2;
localparam [1:0] QUIET  = 2'h3;

reg  [1:0]  state;
reg  [3:0]  count;
reg         event_neg;
wire [15:0] abs_sample = sample[15] ? (16'h0000 - sample) : sample;
wire [7:0]  magnitude  = (abs_sample[15:8] != 8'h00) ? 8'hff : abs_sample[7:0];
wire        over       = (magnitude >= threshold);
wire        raw_neg    = sample[15] ^ direction_swap;
wire        allowed    = event_neg ? neg_enable : pos_enable;

// ----------------------------------------------------------------------------
// Event tracking
// ----------------------------------------------------------------------------
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        state     <= IDLE;
        count     <= 4'h0;
        event_neg <= 1'b0;
        tap_pos   <= 1'b0;
        tap_neg   <= 1'b0;
    end else begin
        tap_pos <= 1'b0;
        tap_neg <= 1'b0;
        if (sample_strobe) begin
            case (state)
                IDLE: begin
                    if (over) begin
                        event_neg <= raw_neg;
                        count     <= 4'h1;
                        state     <= (max_samples == 4'h0) ? REJECT : ABOVE;
                    end
                end
                ABOVE: begin
                    if (over) begin
                        if (count >= max_samples) begin
                            state <= REJECT;
                        end else begin
                            count <= count + 4'h1;
                        end
                    end else if (allowed) begin
                        tap_pos <= ~event_neg;
                        tap_neg <= event_neg;
                        count   <= quiet_samples;
                        state   <= (quiet_samples == 4'h0) ? IDLE : QUIET;
                    end else begin
                        state <= IDLE;
                    end
                end
                REJECT: begin
                    // Long events must fall below threshold before re-arming
                    if (!over) begin
                        state <= IDLE;
                    end
                end
                QUIET: begin
                    if (count <= 4'h1) begin
                        state <= IDLE;
                    end
                    count <= count - 4'h1;
                end
                default: state <= IDLE;
            endcase
        end
    end
end

endmodule // axis_tap_detector

// ==== hw/sample_rate_gen.v ====
// Sample strobe generator for the selected output data rate
`timescale 1ns/1ps
`include "accel_tap_map.vh"
module sample_rate_gen #(
    parameter [31:0] CLK_HZ = `CLK_HZ
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // Control
    input  wire        run,
    input  wire [3:0]  rate_code,
    // Strobe
    output reg         sample_strobe
);

// ----------------------------------------------------------------------------
// Period selection
// ----------------------------------------------------------------------------
reg  [31:0] period;
reg  [31:0] count;
reg         rate_valid;

always @* begin
    rate_valid = 1'b1;
    case (rate_code)
        `RATE_32HZ:       period = CLK_HZ / 32;
        `RATE_16HZ:       period = CLK_HZ / 16;
        `RATE_8HZ:        period = CLK_HZ / 8;
        `RATE_4HZ:        period = CLK_HZ / 4;
        `RATE_2HZ:        period = CLK_HZ / 2;
        `RATE_1HZ:        period = CLK_HZ;
        `RATE_HALF_HZ:    period = CLK_HZ * 2;
        `RATE_QUARTER_HZ: period = CLK_HZ * 4;
        `RATE_64HZ:       period = CLK_HZ / 64;
        `RATE_128HZ:      period = CLK_HZ / 128;
        `RATE_256HZ:      period = CLK_HZ / 256;
        default: begin
            // Reserved codes stop sampling rather than guess a rate
            period     = 32'h0000_0001;
            rate_valid = 1'b0;
        end
    endcase
end

// ----------------------------------------------------------------------------
// Divider
// ----------------------------------------------------------------------------
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        count         <= 32'h0000_0000;
        sample_strobe <= 1'b0;
    end else if (!run || !rate_valid) begin
        count         <= 32'h0000_0000;
        sample_strobe <= 1'b0;
    end else if (count + 32'h0000_0001 >= period) begin
        count         <= 32'h0000_0000;
        sample_strobe <= 1'b1;
    end else begin
        count         <= count + 32'h0000_0001;
        sample_strobe <= 1'b0;
    end
end

endmodule // sample_rate_gen

// ==== test/accel_tap_chk.sv ====
// Port assertions for the tap and rate block
`timescale 1ns/1ps
`include "accel_tap_map.vh"
module accel_tap_chk #(
    parameter [31:0] CLK_HZ = `CLK_HZ
) (
    // Clock and reset
    input wire        clk,
    input wire        rst_b,
    // Register ports
    input wire        wr_en,
    input wire [7:0]  wr_addr,
    input wire [7:0]  wr_data,
    input wire        rd_en,
    input wire [7:0]  rd_addr,
    input wire [7:0]  rd_data,
    input wire        rd_valid,
    // Samples and status
    input wire [15:0] x_sample,
    input wire [15:0] y_sample,
    input wire [15:0] z_sample,
    input wire [5:0]  tap_flags,
    input wire        accel_irq_pin
);
    // Shadows of write-only registers, which cannot be read back
    logic [7:0] feat;
    logic [7:0] ctl;
    logic [7:0] irq_en;
    logic [1:0] mode;
    logic [1:0] idle;
    wire        st_rd = rd_en && (rd_addr == `ADDR_EVENT_FLAGS);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            feat <= 8'h00;
            ctl <= 8'h00;
            irq_en <= 8'h00;
            mode <= 2'h0;
            idle <= 2'h0;
        end else begin
            if (wr_en && wr_addr == `ADDR_RATE_TAP_FEATURE) feat <= wr_data;
            if (wr_en && wr_addr == `ADDR_TAP_CONTROL) ctl <= wr_data;
            if (wr_en && wr_addr == `ADDR_IRQ_ENABLE) irq_en <= wr_data;
            if (wr_en && wr_addr == `ADDR_OPERATING_STATE) mode <= wr_data[1:0];
            idle <= (mode == `STATE_WAKE) ? 2'h0 : ((idle == 2'h3) ? 2'h3 : idle + 2'h1);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_RD_VALID: assert property (rd_en |=> rd_valid)
        else $error("read not answered");
    AST_RD_IDLE: assert property (!rd_en |=> !rd_valid)
        else $error("spurious read valid");
    AST_RD_STATUS: assert property (st_rd |=> rd_data == {2'b00, $past(tap_flags)})
        else $error("status read data wrong");
    AST_RD_OTHER: assert property (rd_en && !st_rd |=> rd_data == 8'h00)
        else $error("other read not zero");
    AST_FLAG_KEEP: assert property (!st_rd |=> (tap_flags & $past(tap_flags)) == $past(tap_flags))
        else $error("flag lost without read");
    AST_LATCH_HOLD: assert property (feat[7] && tap_flags != 6'h00 && !st_rd |=> $stable(tap_flags))
        else $error("latched flags changed");
    AST_LATCH_FIRST: assert property (feat[7] && (tap_flags == 6'h00 || st_rd) |=> $onehot0(tap_flags))
        else $error("latch took several taps");
    AST_IRQ_PIN: assert property (!$past(wr_en) |-> accel_irq_pin == |(tap_flags & irq_en[5:0]))
        else $error("irq pin mismatch");
    AST_GLOBAL_OFF: assert property (!ctl[7] && !$past(ctl[7]) && !$past(ctl[7], 2) |-> (tap_flags & ~$past(tap_flags)) == 6'h00)
        else $error("tap while globally off");
    AST_DIR_GATE: assert property ((tap_flags & ~$past(tap_flags) & ~(ctl[5:0] & $past(ctl[5:0]) & $past(ctl[5:0], 2))) == 6'h00)
        else $error("tap on disabled direction");
    AST_STANDBY: assert property (idle == 2'h3 |-> (tap_flags & ~$past(tap_flags)) == 6'h00)
        else $error("tap outside wake");

    cover property (st_rd && tap_flags != 6'h00);
    cover property (accel_irq_pin);
    cover property (feat[7] && tap_flags != 6'h00);
endmodule // accel_tap_chk

bind accel_tap_detect_rate_ctrl accel_tap_chk #(.CLK_HZ(CLK_HZ)) u_chk (
    .clk(clk), .rst_b(rst_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .x_sample(x_sample), .y_sample(y_sample), .z_sample(z_sample),
    .tap_flags(tap_flags), .accel_irq_pin(accel_irq_pin)
);

// ==== test/tap_host_model.sv ====
// Host model driving the block's register strobes
`timescale 1ns/1ps
module tap_host_model (
    // Clock
    input  wire        clk,
    // Register ports
    output logic       wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic       rd_en,
    output logic [7:0] rd_addr,
    input  wire  [7:0] rd_data,
    input  wire        rd_valid
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        rd_addr = 8'h00;
    end
    // Idle address and data show the inverse of the last value, never a stale match
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        wr_addr = ~a;
        wr_data = ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        #1;
        rd_en = 1'b1;
        rd_addr = a;
        @(posedge clk);
        #1;
        d = rd_data;
        v = rd_valid;
        rd_en = 1'b0;
        rd_addr = ~a;
    endtask
endmodule // tap_host_model

// ==== test/tb_top.sv ====
// Self-checking bench for the tap and rate block
`timescale 1ns/1ps
`include "accel_tap_map.vh"
`define CHECK(nm, want, got) \
    begin \
        n_checks++; \
        if ((got) !== (want)) begin \
            miscompares++; \
            $display("ERROR %s expected %0h seen %0h", nm, want, got); \
        end \
    end
module tb_top;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] xs = 16'h0000;
    logic [15:0] ys = 16'h0000;
    logic [15:0] zs = 16'h0000;
    wire         wr_en, rd_en, rd_valid, accel_irq_pin;
    wire  [7:0]  wr_addr, wr_data, rd_addr, rd_data;
    wire  [5:0]  tap_flags;
    int          miscompares = 0;
    int          n_checks = 0;
    int          per = 2;
    int          i;

    always #10 clk = ~clk;

    // Small clock figure keeps the slowest rate at 2048 cycles per sample
    accel_tap_detect_rate_ctrl #(.CLK_HZ(32'd512)) u_dut (
        .clk(clk), .rst_b(rst_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .x_sample(xs), .y_sample(ys), .z_sample(zs),
        .tap_flags(tap_flags), .accel_irq_pin(accel_irq_pin)
    );
    tap_host_model u_host (
        .clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid)
    );

    task automatic tally_and_finish();
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.write_reg(a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
        logic [7:0] d;
        logic       v;
        u_host.read_reg(a, d, v);
        `CHECK("rd_valid", 1'b1, v)
        `CHECK("rd_data", want, d)
    endtask

    // Sample high for n strobes, then low long enough for the end-of-event strobe
    task automatic tap_case(input int ax, input logic [15:0] v, input int n,
                            input logic [5:0] want, input bit clr);
        int k;
        xs = (ax == 0) ? v : 16'h0000;
        ys = (ax == 1) ? v : 16'h0000;
        zs = (ax == 2) ? v : 16'h0000;
        repeat (n * per) @(posedge clk);
        #1;
        xs = 16'h0000;
        ys = 16'h0000;
        zs = 16'h0000;
        repeat (2 * per + 4) @(posedge clk);
        #1;
        for (k = 0; k < 8 && tap_flags !== want; k++) begin
            @(posedge clk);
            #1;
        end
        `CHECK("tap_flags", want, tap_flags)
        if (tap_flags !== want) tally_and_finish();
        if (clr) begin
            rd_chk(`ADDR_EVENT_FLAGS, {2'b00, want});
            `CHECK("flags_after_read", 6'h00, tap_flags)
        end
    endtask

    initial begin
        #1800000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        `CHECK("flags_reset", 6'h00, tap_flags)
        `CHECK("irq_reset", 1'b0, accel_irq_pin)
        wr(`ADDR_TAP_CONTROL, 8'h40);
        for (i = 0; i < 3; i++) wr(`ADDR_TAP_X_PARAMS + i[7:0], 8'h0a);
        wr(`ADDR_TAP_CONTROL, 8'hbf);
        for (i = 0; i < 3; i++) wr(`ADDR_TAP_X_PARAMS + i[7:0], 8'h02);
        wr(`ADDR_RATE_TAP_FEATURE, 8'h0a);
        wr(8'h55, 8'hff);
        rd_chk(8'h55, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(`ADDR_OPERATING_STATE, i[7:0]);
            tap_case(0, 16'h0014, 2, (i == 1) ? 6'h01 : 6'h00, 1'b1);
        end
        wr(`ADDR_OPERATING_STATE, 8'h01);
        for (i = 0; i < 6; i++) tap_case(i / 2, i[0] ? 16'hffec : 16'h0014, 2, 6'h01 << i, 1'b1);
        wr(`ADDR_RATE_TAP_FEATURE, 8'h7a);
        for (i = 0; i < 6; i++) tap_case(i / 2, i[0] ? 16'hffec : 16'h0014, 2, 6'h01 << (i ^ 1), 1'b1);
        wr(`ADDR_RATE_TAP_FEATURE, 8'h0a);
        tap_case(1, 16'h000a, 2, 6'h04, 1'b1);
        tap_case(1, 16'hfff7, 2, 6'h00, 1'b1);
        tap_case(2, 16'h8000, 2, 6'h20, 1'b1);
        tap_case(0, 16'h0014, 1, 6'h01, 1'b1);
        tap_case(0, 16'h0014, 3, 6'h00, 1'b1);
        wr(`ADDR_TAP_CONTROL, 8'h3f);
        tap_case(0, 16'h0014, 2, 6'h00, 1'b1);
        wr(`ADDR_TAP_CONTROL, 8'h81);
        tap_case(0, 16'hffec, 2, 6'h00, 1'b1);
        tap_case(0, 16'h0014, 2, 6'h01, 1'b1);
        wr(`ADDR_TAP_CONTROL, 8'hbf);
        tap_case(0, 16'h0014, 2, 6'h01, 1'b0);
        tap_case(1, 16'h0014, 2, 6'h05, 1'b1);
        wr(`ADDR_RATE_TAP_FEATURE, 8'h8a);
        tap_case(0, 16'h0014, 2, 6'h01, 1'b0);
        tap_case(1, 16'h0014, 2, 6'h01, 1'b1);
        tap_case(1, 16'h0014, 2, 6'h04, 1'b1);
        wr(`ADDR_RATE_TAP_FEATURE, 8'h0a);
        // Detect enables are already on, so the pin is allowed to follow X+
        wr(`ADDR_IRQ_ENABLE, 8'h01);
        tap_case(1, 16'h0014, 2, 6'h04, 1'b0);
        `CHECK("irq_masked", 1'b0, accel_irq_pin)
        tap_case(0, 16'h0014, 2, 6'h05, 1'b0);
        `CHECK("irq_set", 1'b1, accel_irq_pin)
        rd_chk(`ADDR_EVENT_FLAGS, 8'h05);
        `CHECK("irq_clear", 1'b0, accel_irq_pin)
        for (i = 0; i < 11; i++) begin
            wr(`ADDR_RATE_TAP_FEATURE, (i < 3) ? 8'h0a - i[7:0] : i[7:0] - 8'h03);
            per = 2 << i;
            repeat (2 * per) @(posedge clk);
            #1;
            tap_case(0, 16'h0014, 2, 6'h01, 1'b1);
            tap_case(0, 16'h0014, 3, 6'h00, 1'b1);
        end
        per = 2;
        for (i = 11; i < 16; i++) begin
            wr(`ADDR_RATE_TAP_FEATURE, i[7:0]);
            tap_case(0, 16'h0014, 2, 6'h00, 1'b1);
        end
        wr(`ADDR_RATE_TAP_FEATURE, 8'h0a);
        wr(`ADDR_TAP_CONTROL, 8'h00);
        wr(`ADDR_TAP_X_PARAMS, 8'hf2);
        wr(`ADDR_TAP_CONTROL, 8'hbf);
        tap_case(0, 16'h0014, 2, 6'h01, 1'b1);
        tap_case(0, 16'h0014, 2, 6'h00, 1'b1);
        repeat (40) @(posedge clk);
        #1;
        tap_case(0, 16'h0014, 2, 6'h01, 1'b1);
        tally_and_finish();
    end
endmodule // tb_top
